// *** include/tcic_pkg.sv ***
// Constants, field layouts and carrier types for the 16-bit timer counter
// with input capture. Assumes a 32-bit AXI4-Lite register slave.
package tcic_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] OFS_CAP_LO = 8'h10;
    localparam logic [7:0] OFS_CAP_HI = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    localparam logic [7:0] OFS_IRQEN = 8'h1C;
    localparam logic [7:0] OFS_CMP_CS = 8'h20;
    // Field positions
    localparam int B_OVF = 0;
    localparam int B_CAP = 5;
    localparam int B_CMP_SEL = 2;
    localparam int B_CMP_OUT = 5;
    // Clock source select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_SYS = 3'h1;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // Fixed top values and extremes
    localparam logic [15:0] TOP_8B = 16'h00FF;
    localparam logic [15:0] TOP_9B = 16'h01FF;
    localparam logic [15:0] TOP_10B = 16'h03FF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    // Noise filter sample count
    localparam int FILT_LEN = 4;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control fields held from control registers A and B
    typedef struct packed {
        logic nf_en;         // noise_filter_enable
        logic edge_rise;     // capture_edge_select
        logic [3:0] wgm;     // waveform_mode_field
        logic [2:0] css;     // clock_source_select
    } tcic_ctrl_t;
    localparam tcic_ctrl_t CTRL_RESET = '0;

    // Sticky event flags
    typedef struct packed {
        logic cap;           // capture_flag
        logic ovf;           // overflow_flag
    } tcic_flags_t;
endpackage : tcic_pkg

// *** hw/tcic_timer.sv ***
// 16-bit up/down timer counter with input capture, noise filter and a
// shared high-byte holding register, behind an AXI4-Lite slave.
// Assumes capture_pin, comparator_output, external_clock_pin and
// prescale_tick are synchronous to aclk; prescaler is outside.
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module tcic_timer
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic external_clock_pin,
    input wire logic prescale_tick,
    input wire logic [15:0] compare_a_value,
    input wire logic capture_irq_ack,
    input wire logic overflow_irq_ack,
    output logic capture_irq,
    output logic overflow_irq,
    output logic count_at_top,
    output logic count_at_bottom
);
    import tcic_pkg::*;

    // Mode classification helpers
    function automatic logic cap_is_top(input logic [3:0] m);
        cap_is_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC)
            || (m == 4'hE);
    endfunction : cap_is_top

    function automatic logic is_dual(input logic [3:0] m);
        is_dual = ((m >= 4'h1) && (m <= 4'h3))
            || ((m >= 4'h8) && (m <= 4'hB));
    endfunction : is_dual

    function automatic logic is_fast(input logic [3:0] m);
        is_fast = ((m >= 4'h5) && (m <= 4'h7)) || (m == 4'hE)
            || (m == 4'hF);
    endfunction : is_fast

    function automatic logic [15:0] top_of(input logic [3:0] m,
        input logic [15:0] cap, input logic [15:0] cmpa);
        unique case (m)
            4'h1, 4'h5: top_of = TOP_8B;
            4'h2, 4'h6: top_of = TOP_9B;
            4'h3, 4'h7: top_of = TOP_10B;
            4'h4, 4'h9, 4'hB, 4'hF: top_of = cmpa;
            4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
            default: top_of = CNT_MAX;
        endcase
    endfunction : top_of

    tcic_ctrl_t ctrl_q;
    tcic_flags_t flag_q;
    tcic_flags_t irqen_q;
    logic cmp_sel_q;
    logic [15:0] cnt_q;
    logic [15:0] cap_q;
    logic [7:0] hold_q;
    logic down_q;
    logic aw_ready_q;
    logic w_ready_q;
    logic b_valid_q;
    logic [1:0] b_resp_q;
    logic ar_ready_q;
    logic r_valid_q;
    logic [31:0] r_data_q;
    logic [1:0] r_resp_q;
    logic [7:0] wa_q;
    logic [7:0] wd_q;
    logic ws_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_prev_q;
    logic in_s1_q;
    logic in_s2_q;
    logic [FILT_LEN-2:0] filt_sh_q;
    logic filt_q;
    logic lvl_prev_q;
    logic top_q;
    logic bottom_q;
    logic cap_irq_q;
    logic ovf_irq_q;

    logic do_wr;
    logic wr_en;
    logic wr_mapped;
    logic rd_en;
    logic wr_cnt_lo;
    logic wr_cap_lo;
    logic wr_hi;
    logic rd_cnt_lo;
    logic rd_cap_lo;
    logic tick;
    logic [15:0] top_val;
    logic [15:0] cnt_d;
    logic down_d;
    logic ovf_evt;
    logic lvl;
    logic cap_evt;
    logic [31:0] rd_word;
    logic rd_mapped;

    // AXI write: address and data are taken in either order
    assign do_wr = !aw_ready_q && !w_ready_q && !b_valid_q;
    assign wr_mapped = (wa_q <= OFS_CMP_CS) && (wa_q[1:0] == 2'h0);
    assign wr_en = do_wr && ws_q && wr_mapped;
    assign wr_cnt_lo = wr_en && (wa_q == OFS_CNT_LO);
    assign wr_cap_lo = wr_en && (wa_q == OFS_CAP_LO);
    assign wr_hi = wr_en && ((wa_q == OFS_CNT_HI) || (wa_q == OFS_CAP_HI));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ready_q <= 1'b1;
            w_ready_q <= 1'b1;
            b_valid_q <= 1'b0;
            b_resp_q <= RESP_OKAY;
            wa_q <= 8'h00;
            wd_q <= 8'h00;
            ws_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && aw_ready_q)
            begin
                aw_ready_q <= 1'b0;
                wa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && w_ready_q)
            begin
                w_ready_q <= 1'b0;
                wd_q <= s_axi_wdata[7:0];
                ws_q <= s_axi_wstrb[0];
            end
            if (do_wr)
            begin
                b_valid_q <= 1'b1;
                b_resp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                aw_ready_q <= 1'b1;
                w_ready_q <= 1'b1;
            end
            else if (b_valid_q && s_axi_bready)
            begin
                b_valid_q <= 1'b0;
            end
        end
    end

    // Read mux; upper locations return the shared holding register
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_mapped = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL_A: rd_word[1:0] = ctrl_q.wgm[1:0];
            OFS_CTRL_B: rd_word[7:0] = {ctrl_q.nf_en, ctrl_q.edge_rise,
                1'b0, ctrl_q.wgm[3:2], ctrl_q.css};
            OFS_CNT_LO: rd_word[7:0] = cnt_q[7:0];
            OFS_CNT_HI, OFS_CAP_HI: rd_word[7:0] = hold_q;
            OFS_CAP_LO: rd_word[7:0] = cap_q[7:0];
            OFS_FLAGS:
            begin
                rd_word[B_CAP] = flag_q.cap;
                rd_word[B_OVF] = flag_q.ovf;
            end
            OFS_IRQEN:
            begin
                rd_word[B_CAP] = irqen_q.cap;
                rd_word[B_OVF] = irqen_q.ovf;
            end
            OFS_CMP_CS:
            begin
                rd_word[B_CMP_SEL] = cmp_sel_q;
                rd_word[B_CMP_OUT] = comparator_output;
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    assign rd_en = s_axi_arvalid && ar_ready_q;
    assign rd_cnt_lo = rd_en && (s_axi_araddr == OFS_CNT_LO);
    assign rd_cap_lo = rd_en && (s_axi_araddr == OFS_CAP_LO);

    // AXI read: answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ar_ready_q <= 1'b1;
            r_valid_q <= 1'b0;
            r_data_q <= 32'h0000_0000;
            r_resp_q <= RESP_OKAY;
        end
        else if (rd_en)
        begin
            ar_ready_q <= 1'b0;
            r_valid_q <= 1'b1;
            r_data_q <= rd_word;
            r_resp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (r_valid_q && s_axi_rready)
        begin
            r_valid_q <= 1'b0;
            ar_ready_q <= 1'b1;
        end
    end

    // Control registers; edge and filter bits act immediately
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= CTRL_RESET;
            irqen_q <= '0;
            cmp_sel_q <= 1'b0;
        end
        else if (wr_en)
        begin
            unique case (wa_q)
                OFS_CTRL_A: ctrl_q.wgm[1:0] <= wd_q[1:0];
                OFS_CTRL_B:
                begin
                    ctrl_q.nf_en <= wd_q[7];
                    ctrl_q.edge_rise <= wd_q[6];
                    ctrl_q.wgm[3:2] <= wd_q[4:3];
                    ctrl_q.css <= wd_q[2:0];
                end
                OFS_IRQEN:
                begin
                    irqen_q.cap <= wd_q[B_CAP];
                    irqen_q.ovf <= wd_q[B_OVF];
                end
                OFS_CMP_CS: cmp_sel_q <= wd_q[B_CMP_SEL];
                default: ;
            endcase
        end
    end

    // One holding register for counter and capture pairs; low-byte
    // writes leave it alone so one upper write serves many pairs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hold_q <= 8'h00;
        else if (wr_hi)
            hold_q <= wd_q;
        else if (rd_cnt_lo)
            hold_q <= cnt_q[15:8];
        else if (rd_cap_lo)
            hold_q <= cap_q[15:8];
    end

    // External clock pin sampled then edge detected into a timer tick
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= external_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
        end
    end

    always_comb
    begin
        unique case (ctrl_q.css)
            CS_STOP: tick = 1'b0;
            CS_SYS: tick = 1'b1;
            CS_EXT_FALL: tick = ext_prev_q && !ext_s2_q;
            CS_EXT_RISE: tick = !ext_prev_q && ext_s2_q;
            default: tick = prescale_tick;
        endcase
    end

    // Next count: wrap at top, or turn round in dual-slope modes
    assign top_val = top_of(ctrl_q.wgm, cap_q, compare_a_value);
    always_comb
    begin
        cnt_d = cnt_q;
        down_d = down_q;
        if (is_dual(ctrl_q.wgm))
        begin
            if (!down_q && (cnt_q >= top_val))
            begin
                down_d = 1'b1;
                cnt_d = cnt_q - 16'h0001;
            end
            else if (down_q && (cnt_q == CNT_BOTTOM))
            begin
                down_d = 1'b0;
                cnt_d = 16'h0001;
            end
            else
                cnt_d = down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end
        else if (cnt_q == top_val)
            cnt_d = CNT_BOTTOM;
        else
            cnt_d = cnt_q + 16'h0001;
    end

    // Overflow point depends on the waveform mode
    assign ovf_evt = tick && !wr_cnt_lo && (is_dual(ctrl_q.wgm)
        ? (down_q && (cnt_q == CNT_BOTTOM))
        : (is_fast(ctrl_q.wgm) ? (cnt_q == top_val)
        : (cnt_q == CNT_MAX)));

    // Counter; a CPU write overrides any count or clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= CNT_BOTTOM;
            down_q <= 1'b0;
        end
        else if (wr_cnt_lo)
            cnt_q <= {hold_q, wd_q};
        else if (tick)
        begin
            cnt_q <= cnt_d;
            down_q <= down_d;
        end
    end

    // Top and bottom indicators follow the stored count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            top_q <= 1'b0;
            bottom_q <= 1'b0;
        end
        else
        begin
            top_q <= (cnt_q == top_val);
            bottom_q <= (cnt_q == CNT_BOTTOM);
        end
    end

    // Trigger source sampled like the clock pin; a switch of source
    // can look like an edge, so software clears the flag afterwards
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
        end
        else
        begin
            in_s1_q <= cmp_sel_q ? comparator_output : capture_pin;
            in_s2_q <= in_s1_q;
        end
    end

    // Noise filter: output moves only when four samples agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            filt_sh_q <= '0;
            filt_q <= 1'b0;
        end
        else
        begin
            filt_sh_q <= {filt_sh_q[FILT_LEN-3:0], in_s2_q};
            if (&{filt_sh_q, in_s2_q})
                filt_q <= 1'b1;
            else if (~|{filt_sh_q, in_s2_q})
                filt_q <= 1'b0;
        end
    end

    // Edge detector, disabled while the capture register is top
    assign lvl = ctrl_q.nf_en ? filt_q : in_s2_q;
    assign cap_evt = !cap_is_top(ctrl_q.wgm) && (lvl != lvl_prev_q)
        && (lvl == ctrl_q.edge_rise);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lvl_prev_q <= 1'b0;
        else
            lvl_prev_q <= lvl;
    end

    // Capture register; each event overwrites the previous value
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cap_q <= 16'h0000;
        else if (cap_evt)
            cap_q <= cnt_q;
        else if (wr_cap_lo && cap_is_top(ctrl_q.wgm))
            cap_q <= {hold_q, wd_q};
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_q <= '0;
        else
        begin
            if (cap_evt)
                flag_q.cap <= 1'b1;
            else if (capture_irq_ack
                || (wr_en && (wa_q == OFS_FLAGS) && wd_q[B_CAP]))
                flag_q.cap <= 1'b0;
            if (ovf_evt)
                flag_q.ovf <= 1'b1;
            else if (overflow_irq_ack
                || (wr_en && (wa_q == OFS_FLAGS) && wd_q[B_OVF]))
                flag_q.ovf <= 1'b0;
        end
    end

    // Interrupt requests from flag and enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cap_irq_q <= 1'b0;
            ovf_irq_q <= 1'b0;
        end
        else
        begin
            cap_irq_q <= flag_q.cap && irqen_q.cap;
            ovf_irq_q <= flag_q.ovf && irqen_q.ovf;
        end
    end

    assign s_axi_awready = aw_ready_q;
    assign s_axi_wready = w_ready_q;
    assign s_axi_bvalid = b_valid_q;
    assign s_axi_bresp = b_resp_q;
    assign s_axi_arready = ar_ready_q;
    assign s_axi_rvalid = r_valid_q;
    assign s_axi_rdata = r_data_q;
    assign s_axi_rresp = r_resp_q;
    assign capture_irq = cap_irq_q;
    assign overflow_irq = ovf_irq_q;
    assign count_at_top = top_q;
    assign count_at_bottom = bottom_q;

    // Checks
    chk_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_q.css == CS_STOP) && !wr_cnt_lo |=> $stable(cnt_q))
        else $error("counter moved while stopped");
    chk_cnt_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_cnt_lo |=> cnt_q == {$past(hold_q), $past(wd_q)})
        else $error("counter write lost");
    chk_hold_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_cnt_lo || wr_cap_lo) && !rd_en |=> $stable(hold_q))
        else $error("holding register changed on low write");
    chk_count_step: assert property (@(posedge aclk)
        disable iff (!aresetn) tick && !wr_cnt_lo && (ctrl_q.wgm == 4'h0)
        |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("normal mode did not increment");
    chk_capture_copy: assert property (@(posedge aclk)
        disable iff (!aresetn)
        cap_evt |=> (cap_q == $past(cnt_q)) && flag_q.cap)
        else $error("capture copy or flag missing");
    chk_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        capture_irq_ack && !cap_evt |=> !flag_q.cap)
        else $error("capture flag not cleared");
    chk_cap_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_cap_lo && !cap_is_top(ctrl_q.wgm) && !cap_evt
        |=> $stable(cap_q))
        else $error("capture written outside top mode");
    chk_lo_read_hold: assert property (@(posedge aclk)
        disable iff (!aresetn) rd_cap_lo && !wr_hi
        |=> hold_q == $past(cap_q[15:8]))
        else $error("capture low read did not load holding");
    chk_filter_agree: assert property (@(posedge aclk)
        disable iff (!aresetn) $rose(filt_q)
        |-> $past(in_s2_q) && $past(in_s2_q, 2) && $past(in_s2_q, 3)
        && $past(in_s2_q, 4))
        else $error("filter moved without four equal samples");
    chk_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        flag_q.cap && irqen_q.cap |=> capture_irq)
        else $error("capture irq not raised");
endmodule : tcic_timer

// *** verification/tcic_event_src.sv ***
// Pin and prescaler source around the timer, driven as software would.
// Assumes callers share aclk; every change lands just after an edge.
`timescale 1ns/1ns
module tcic_event_src
(
    input wire logic aclk,
    output logic capture_pin,
    output logic comparator_output,
    output logic external_clock_pin,
    output logic prescale_tick
);
    // Quiet levels from time zero
    initial
    begin
        capture_pin = 1'b0;
        comparator_output = 1'b0;
        external_clock_pin = 1'b0;
        prescale_tick = 1'b0;
    end

    // Levels hold between calls, like a port bit
    task set_pin(input logic v);
        @(posedge aclk);
        capture_pin <= v;
    endtask : set_pin

    task set_cmp(input logic v);
        @(posedge aclk);
        comparator_output <= v;
    endtask : set_cmp

    // One-cycle pulses with a gap, as a prescaler gives
    task tick(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            prescale_tick <= 1'b1;
            @(posedge aclk);
            prescale_tick <= 1'b0;
        end
    endtask : tick

    // Slow external clock so each edge is sampled cleanly
    task ext(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge aclk);
            external_clock_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            external_clock_pin <= 1'b0;
        end
    endtask : ext
endmodule : tcic_event_src

// *** verification/test_tcic_timer.sv ***
// Self-checking bench for the capture timer over AXI4-Lite.
// Assumes tcic_pkg offsets and the event source model beside the dut.
`timescale 1ns/1ns
module test_tcic_timer;
    import tcic_pkg::*;
    logic aclk = 1'b0;
    logic aresetn;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready;
    logic arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic cap_pin, cmp_out, ext_pin, ptick;
    logic [15:0] cmpa;
    logic cap_ack, ovf_ack;
    logic cap_irq, ovf_irq, at_top, at_bot;
    int errors = 0;
    int checked = 0;

    // 25 MHz system clock
    always #20 aclk = ~aclk;

    tcic_timer dut_u
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capture_pin(cap_pin),
        .comparator_output(cmp_out), .external_clock_pin(ext_pin),
        .prescale_tick(ptick), .compare_a_value(cmpa),
        .capture_irq_ack(cap_ack), .overflow_irq_ack(ovf_ack),
        .capture_irq(cap_irq), .overflow_irq(ovf_irq),
        .count_at_top(at_top), .count_at_bottom(at_bot)
    );

    tcic_event_src src_u
    (
        .aclk(aclk), .capture_pin(cap_pin),
        .comparator_output(cmp_out), .external_clock_pin(ext_pin),
        .prescale_tick(ptick)
    );

    // Four-state compare so an unknown never matches
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Write: address and data offered together, each held until taken
    task wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask : wr

    // Read: rready held until rvalid is seen at an edge
    task rd(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h0, d});
        chk(rresp, er);
    endtask : rd

    // Upper byte first on write, lower byte first on read
    task wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h04, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16

    task rd16(input logic [7:0] a, input logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h04, v[15:8]);
    endtask : rd16

    task test_done;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Run takes a few hundred cycles; far beyond means a hang
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        test_done;
    end

    // Main sequence; counter stays stopped unless a test starts it
    initial
    begin
        // Idle bus and quiet inputs while reset is held
        aresetn <= 1'b0;
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata <= 32'h0000_0000;
        wstrb <= 4'hF;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        arvalid <= 1'b0;
        rready <= 1'b0;
        cmpa <= 16'h0000;
        cap_ack <= 1'b0;
        ovf_ack <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(at_bot, 1'b1);
        wr16(OFS_CNT_LO, 16'h1234);
        wr(OFS_CNT_LO, 8'h56);
        repeat (10) @(posedge aclk);
        rd16(OFS_CNT_LO, 16'h1256);
        // Lane 0 off: answered OKAY but the counter must not move
        wstrb <= 4'hE;
        wr(OFS_CNT_LO, 8'h99);
        wstrb <= 4'hF;
        rd(OFS_CNT_LO, 8'h56);
        wr(OFS_IRQEN, 8'h21);
        wr16(OFS_CNT_LO, 16'hFFFE);
        wr(OFS_CTRL_B, 8'h02);
        src_u.tick(3);
        wr(OFS_CTRL_B, 8'h00);
        rd16(OFS_CNT_LO, 16'h0001);
        rd(OFS_FLAGS, 8'h01);
        chk(ovf_irq, 1'b1);
        @(posedge aclk);
        ovf_ack <= 1'b1;
        @(posedge aclk);
        ovf_ack <= 1'b0;
        rd(OFS_FLAGS, 8'h00);
        // Dual slope turns at 0x00FF, then counts down
        wr16(OFS_CNT_LO, 16'h00FE);
        wr(OFS_CTRL_A, 8'h01);
        wr(OFS_CTRL_B, 8'h02);
        src_u.tick(3);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_A, 8'h00);
        rd16(OFS_CNT_LO, 16'h00FD);
        // Clear-on-compare top comes from the compare input
        cmpa <= 16'h0010;
        wr16(OFS_CNT_LO, 16'h000F);
        wr(OFS_CTRL_B, 8'h0A);
        src_u.tick(2);
        wr(OFS_CTRL_B, 8'h00);
        rd16(OFS_CNT_LO, 16'h0000);
        wr16(OFS_CNT_LO, 16'hFFFF);
        repeat (2) @(posedge aclk);
        chk(at_top, 1'b1);
        wr16(OFS_CNT_LO, 16'h0000);
        wr(OFS_CTRL_B, 8'h07);
        src_u.ext(2);
        wr(OFS_CTRL_B, 8'h00);
        rd16(OFS_CNT_LO, 16'h0002);
        $display("test counter done");
        wr16(OFS_CNT_LO, 16'h1234);
        wr(OFS_CTRL_B, 8'h40);
        src_u.set_pin(1'b1);
        repeat (6) @(posedge aclk);
        rd(OFS_FLAGS, 8'h20);
        chk(cap_irq, 1'b1);
        rd16(OFS_CAP_LO, 16'h1234);
        wr16(OFS_CNT_LO, 16'h5678);
        wr(OFS_CTRL_B, 8'h00);
        src_u.set_pin(1'b0);
        repeat (6) @(posedge aclk);
        rd16(OFS_CAP_LO, 16'h5678);
        wr(OFS_CTRL_B, 8'hC0);
        wr(OFS_FLAGS, 8'h20);
        rd(OFS_FLAGS, 8'h00);
        $display("test capture done");
        // A three-sample pulse must not get through the filter
        src_u.set_pin(1'b1);
        repeat (2) @(posedge aclk);
        src_u.set_pin(1'b0);
        repeat (8) @(posedge aclk);
        rd(OFS_FLAGS, 8'h00);
        src_u.set_pin(1'b1);
        repeat (5) @(posedge aclk);
        chk(cap_irq, 1'b0);
        repeat (4) @(posedge aclk);
        chk(cap_irq, 1'b1);
        cap_ack <= 1'b1;
        @(posedge aclk);
        cap_ack <= 1'b0;
        rd(OFS_FLAGS, 8'h00);
        $display("test filter done");
        wr(OFS_CTRL_B, 8'h40);
        wr(OFS_CMP_CS, 8'h04);
        wr(OFS_FLAGS, 8'h21);
        wr16(OFS_CNT_LO, 16'h0777);
        src_u.set_cmp(1'b1);
        repeat (6) @(posedge aclk);
        rd16(OFS_CAP_LO, 16'h0777);
        wr16(OFS_CAP_LO, 16'h1111);
        rd16(OFS_CAP_LO, 16'h0777);
        // Mode 12: capture register is top, capture input is off
        wr(OFS_CMP_CS, 8'h00);
        wr(OFS_CTRL_B, 8'h18);
        wr(OFS_FLAGS, 8'h21);
        wr(OFS_CNT_HI, 8'h0A);
        wr(OFS_CAP_LO, 8'hBC);
        rd16(OFS_CAP_LO, 16'h0ABC);
        src_u.set_pin(1'b0);
        repeat (6) @(posedge aclk);
        rd(OFS_FLAGS, 8'h00);
        wr(8'h24, 8'h01, RESP_SLVERR);
        rd(8'h24, 8'h00, RESP_SLVERR);
        $display("test source and mode done");
        test_done;
    end
endmodule : test_tcic_timer
